// File: rtl/asu_core.sv
`timescale 1ns/1ps
// Operation
// - Frame is low start bit, data, optional parity, high stop bits.
// - Transmitter sends one or two stop bits per stop length select.
// - Parity add bit enables parity; parity type bit picks even or odd.
// - Baud select codes 0 to 5 divide system clock, each halving rate.
// - Code 110 uses source clock over timer match value, sixteen ticks a bit.
// - Idle receiver samples input each tick; low level begins start bit.
// - Each received bit sampled at ticks 7, 8, 9; majority wins.
// - Buffer write after status read clears empty flag and starts sending.
// - Shift start sets transmit empty flag and pulses transmit request.
// - Serial output stays high before first byte, and while disabled once the current frame ends.
// - Buffer write without prior status read is ignored entirely.
// - After stop bit, data goes to holding buffer, full flag, request.
// - Frame arriving while buffer unread sets overrun, data discarded.
// - Receiver ignores new frames until overrun flag is cleared.
// - Parity mismatch between data and parity bit sets parity error.
// - Stop bit sampled low sets framing error flag.
// - Receive flags clear only on buffer read after status read.
// - Overrun set after the status read survives the buffer read.
// - Transmit end sets when frame done and buffer empty; new send clears.
// - Receive disable takes effect only once current reception ends.
// - One baud setting and one parity setting serve both directions.
module asu_core (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       rxd,
  output logic            txd,
  output logic            tx_irq,
  output logic            rx_irq
);
  import asu_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  ctrl;
  logic [7:0]  tmatch;
  logic        rd_armed;
  logic        overrun_flag_seen;
  logic [11:0] div_cnt;
  logic        tick;
  logic        rxd_meta;
  logic        rxd_s;
  // Transmit side
  asu_tx_e     tx_state;
  logic [7:0]  tx_hold;
  logic        tx_pending;
  logic        tx_empty;
  logic        tx_done;
  logic [11:0] tx_frame;
  logic [3:0]  tx_left;
  logic [3:0]  tx_tick;
  // Receive side
  asu_rx_e     rx_state;
  logic [3:0]  rx_tick;
  logic [3:0]  rx_bit;
  logic [2:0]  rx_votes;
  logic [7:0]  rx_data;
  logic        rx_par;
  logic [7:0]  rx_buf;
  logic        rx_full;
  logic        parity_error_flag;
  logic        framing_error_flag;
  logic        overrun_flag;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire sts_rd   = rd_stb && (addr == ASU_STATUS_ADDR);
  wire buf_rd   = rd_stb && (addr == ASU_BUF_ADDR);
  wire ctrl_wr  = wr_stb && (addr == ASU_CTRL_ADDR);
  wire tm_wr    = wr_stb && (addr == ASU_TMATCH_ADDR);
  wire buf_wr   = wr_stb && (addr == ASU_BUF_ADDR);
  wire tx_accept = buf_wr && rd_armed;
  wire rx_clear  = buf_rd && rd_armed;
  wire [7:0] status = {parity_error_flag, framing_error_flag, overrun_flag, rx_full, tx_done, tx_empty, 2'b00};
  wire [7:0] rd_mux = sts_rd ? status :
                      buf_rd ? rx_buf :
                      (rd_stb && addr == ASU_TMATCH_ADDR) ? tmatch : 8'h00;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl      <= ASU_CTRL_RST;
      tmatch    <= ASU_TMATCH_RST;
      rdata     <= 8'h00;
      rd_armed  <= 1'b0;
      overrun_flag_seen <= 1'b0;
    end else begin
      if (ctrl_wr) ctrl <= wdata;
      if (tm_wr) tmatch <= wdata;
      rdata <= rd_mux;
      if (sts_rd) begin
        rd_armed  <= 1'b1;
        overrun_flag_seen <= overrun_flag;
      end else if (buf_rd || buf_wr) begin
        rd_armed <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared transfer clock, sixteen ticks per bit
  wire [2:0]  baud_select_field = ctrl[ASU_BRG +: 3];
  wire [11:0] tm_div = (tmatch == 8'h00) ? 12'h001 : {4'h0, tmatch};
  wire [11:0] div_lim = (baud_select_field == ASU_BRG_TIMER) ? tm_div :
                        (ASU_DIV_BASE << baud_select_field);
  wire div_run = (baud_select_field <= ASU_BRG_LAST) || (baud_select_field == ASU_BRG_TIMER);
  wire div_end = div_cnt >= (div_lim - 12'h001);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_cnt <= 12'h000;
      tick    <= 1'b0;
    end else begin
      div_cnt <= (div_end || !div_run) ? 12'h000 : div_cnt + 12'h001;
      tick    <= div_end && div_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  wire tx_par   = asu_parity(tx_hold, ctrl[ASU_EVEN]);
  wire tx_start = (tx_state == ASU_TX_IDLE) && tx_pending && ctrl[ASU_TXE];
  wire tx_bit_end = tick && (tx_tick == ASU_TICK_LAST);
  wire tx_end   = (tx_state == ASU_TX_SEND) && tx_bit_end &&
                  (tx_left == 4'h1);
  wire [11:0] next_frame = ctrl[ASU_PE] ?
                           {2'b11, tx_par, tx_hold, 1'b0} :
                           {3'b111, tx_hold, 1'b0};
  wire [3:0] next_left = ASU_FRAME_MIN + {3'b000, ctrl[ASU_PE]} +
                         {3'b000, ctrl[ASU_STOP]};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_state   <= ASU_TX_IDLE;
      tx_hold    <= ASU_BUF_RST;
      tx_pending <= 1'b0;
      tx_empty   <= 1'b1;
      tx_done    <= 1'b1;
      tx_frame   <= 12'hFFF;
      tx_left    <= 4'h0;
      tx_tick    <= 4'h0;
      txd        <= 1'b1;
      tx_irq     <= 1'b0;
    end else begin
      tx_irq <= tx_start;
      if (tx_accept) tx_hold <= wdata;
      tx_pending <= tx_accept || (tx_pending && !tx_start);
      if (tx_accept) tx_empty <= 1'b0;
      else if (tx_start) tx_empty <= 1'b1;
      if (tx_start) tx_done <= 1'b0;
      else if (tx_end && !tx_pending) tx_done <= 1'b1;
      unique case (tx_state)
        ASU_TX_IDLE: begin
          txd <= 1'b1;
          if (tx_start) begin
            tx_state <= ASU_TX_SEND;
            tx_frame <= next_frame;
            tx_left  <= next_left;
            tx_tick  <= 4'h0;
            txd      <= 1'b0;
          end
        end
        ASU_TX_SEND: begin
          if (tick) tx_tick <= tx_tick + 4'h1;
          if (tx_bit_end) begin
            tx_frame <= {1'b1, tx_frame[11:1]};
            tx_left  <= tx_left - 4'h1;
            txd      <= tx_frame[1];
            if (tx_end) begin
              tx_state <= ASU_TX_IDLE;
              txd      <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver; the first sync stage feeds only the second
  wire rx_vote = (rx_votes[0] & rx_votes[1]) | (rx_votes[0] & rx_votes[2]) |
                 (rx_votes[1] & rx_votes[2]);
  wire [3:0] rx_last = ASU_RX_STOP + {3'b000, ctrl[ASU_PE]};
  wire rx_bit_end = (rx_state == ASU_RX_BUSY) && tick &&
                    (rx_tick == ASU_TICK_LAST);
  wire rx_false = rx_bit_end && (rx_bit == 4'h0) && rx_vote;
  wire rx_finish = rx_bit_end && (rx_bit == rx_last);
  wire rx_go = (rx_state == ASU_RX_IDLE) && tick && !rxd_s &&
               ctrl[ASU_RXE] && !overrun_flag;
  wire rx_load = rx_finish && !rx_full;
  wire rx_ovr  = rx_finish && rx_full;
  wire par_bad = ctrl[ASU_PE] &&
                 (asu_parity(rx_data, ctrl[ASU_EVEN]) != rx_par);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxd_meta <= 1'b1;
      rxd_s    <= 1'b1;
      rx_state <= ASU_RX_IDLE;
      rx_tick  <= 4'h0;
      rx_bit   <= 4'h0;
      rx_votes <= 3'b111;
      rx_data  <= 8'h00;
      rx_par   <= 1'b0;
    end else begin
      rxd_meta <= rxd;
      rxd_s    <= rxd_meta;
      unique case (rx_state)
        ASU_RX_IDLE: begin
          if (rx_go) begin
            rx_state <= ASU_RX_BUSY;
            rx_tick  <= 4'h1;
            rx_bit   <= 4'h0;
          end
        end
        ASU_RX_BUSY: begin
          if (tick) begin
            rx_tick <= rx_tick + 4'h1;
            if (rx_tick == ASU_TICK_S0) rx_votes[0] <= rxd_s;
            if (rx_tick == ASU_TICK_S1) rx_votes[1] <= rxd_s;
            if (rx_tick == ASU_TICK_S2) rx_votes[2] <= rxd_s;
          end
          if (rx_bit_end) begin
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit >= 4'h1 && rx_bit <= 4'h8)
              rx_data <= {rx_vote, rx_data[7:1]};
            if (rx_bit == ASU_RX_STOP && ctrl[ASU_PE]) rx_par <= rx_vote;
            if (rx_false || rx_finish) rx_state <= ASU_RX_IDLE;
          end
        end
      endcase
    end
  end

  // Flags: hardware set wins over a same-cycle software clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_buf  <= ASU_BUF_RST;
      rx_full <= 1'b0;
      parity_error_flag    <= 1'b0;
      framing_error_flag    <= 1'b0;
      overrun_flag    <= 1'b0;
      rx_irq  <= 1'b0;
    end else begin
      rx_irq <= rx_load;
      if (rx_load) rx_buf <= rx_data;
      rx_full <= rx_load || (rx_full && !rx_clear);
      parity_error_flag <= (rx_finish && par_bad) || (parity_error_flag && !rx_clear);
      framing_error_flag <= (rx_finish && !rx_vote) || (framing_error_flag && !rx_clear);
      overrun_flag <= rx_ovr || (overrun_flag && !(rx_clear && overrun_flag_seen));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  txd_idle_a: assert property (
    tx_state == ASU_TX_IDLE && !tx_start |=> txd)
    else $error("txd low while transmitter idle");
  tx_start_a: assert property (
    tx_start && !tx_accept |=> tx_empty && tx_irq && !txd)
    else $error("shift start did not set empty and request");
  tx_gate_a: assert property (
    buf_wr && !rd_armed && !tx_pending |=> !tx_pending)
    else $error("unarmed buffer write accepted");
  tx_end_a: assert property (
    tx_start |=> !tx_done ##0 (tx_state == ASU_TX_SEND))
    else $error("transmit end not cleared on start");
  rx_load_a: assert property (
    rx_finish && !rx_full |=> rx_full && rx_irq && rx_buf == $past(rx_data))
    else $error("received byte not loaded");
  ovr_keep_a: assert property (
    rx_finish && rx_full |=> overrun_flag && $stable(rx_buf) && !rx_irq)
    else $error("overrun did not hold buffer");
  rx_block_a: assert property (
    overrun_flag && rx_state == ASU_RX_IDLE ##1 overrun_flag |-> rx_state == ASU_RX_IDLE)
    else $error("reception started during overrun");
  framing_error_flag_set_a: assert property (
    rx_finish && !rx_vote |=> framing_error_flag)
    else $error("framing error missed");
  ovr_late_a: assert property (
    buf_rd && rd_armed && overrun_flag && !overrun_flag_seen |=> overrun_flag)
    else $error("late overrun cleared");

  tx_frame_c: cover property (tx_end && !tx_pending);
  rx_frame_c: cover property (rx_load && ctrl[ASU_PE]);
  rx_ovr_c: cover property (rx_ovr);
  rx_framing_error_flag_c: cover property (rx_finish && !rx_vote);
endmodule // asu_core

// File: rtl/asu_pkg.sv
package asu_pkg;
  // Register map, byte offsets on the plain port
  localparam logic [7:0] ASU_STATUS_ADDR = 8'h25; // Read side
  localparam logic [7:0] ASU_CTRL_ADDR   = 8'h25; // Write side
  localparam logic [7:0] ASU_TMATCH_ADDR = 8'h26;
  localparam logic [7:0] ASU_BUF_ADDR    = 8'h27;
  // Control bits of serial_control_one
  localparam int ASU_TXE  = 7;
  localparam int ASU_RXE  = 6;
  localparam int ASU_STOP = 5;
  localparam int ASU_EVEN = 4;
  localparam int ASU_PE   = 3;
  localparam int ASU_BRG  = 0;
  // Status bits of uart_flags_status
  localparam int ASU_PARITY_ERROR_FLAG = 7;
  localparam int ASU_FRAMING_ERROR_FLAG = 6;
  localparam int ASU_OVERRUN_FLAG = 5;
  localparam int ASU_RX_FULL_FLAG = 4;
  localparam int ASU_TX_DONE_FLAG = 3;
  localparam int ASU_TX_EMPTY_FLAG = 2;
  // Reset values
  localparam logic [7:0] ASU_CTRL_RST   = 8'h00;
  localparam logic [7:0] ASU_TMATCH_RST = 8'h01;
  localparam logic [7:0] ASU_BUF_RST    = 8'h00;
  // Transfer clock dividers
  localparam logic [11:0] ASU_DIV_BASE  = 12'h00D;
  localparam logic [2:0]  ASU_BRG_TIMER = 3'h6;
  localparam logic [2:0]  ASU_BRG_LAST  = 3'h5;
  // Sample tick positions within one bit
  localparam logic [3:0] ASU_TICK_S0   = 4'h7;
  localparam logic [3:0] ASU_TICK_S1   = 4'h8;
  localparam logic [3:0] ASU_TICK_S2   = 4'h9;
  localparam logic [3:0] ASU_TICK_LAST = 4'hF;
  // Frame bit counts
  localparam logic [3:0] ASU_FRAME_MIN = 4'hA;
  localparam logic [3:0] ASU_RX_STOP   = 4'h9;

  typedef enum logic {ASU_TX_IDLE, ASU_TX_SEND} asu_tx_e;
  typedef enum logic {ASU_RX_IDLE, ASU_RX_BUSY} asu_rx_e;

  function automatic logic asu_parity(input logic [7:0] d,
                                      input logic       even);
    return (^d) ^ ~even;
  endfunction
endpackage

// File: testbench/asu_remote.sv
`timescale 1ns/1ps
module asu_remote (
  input  wire logic        core_clk,
  input  wire logic        txd,
  input  wire logic [15:0] bit_clks,
  input  wire logic        pe,
  input  wire logic        even,
  output logic             rxd,
  output logic             got,
  output logic       [7:0] got_byte,
  output logic             got_bad
);
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    got_byte = 8'h00;
    got_bad = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One frame, then an idle bit so the far end settles before software looks
  task automatic send(input logic [7:0] d, input logic bp, input logic bs);
    logic [10:0] f;
    f = pe ? {~bs, (^d) ^ ~even ^ bp, d, 1'b0} : {1'b1, ~bs, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      tick(bit_clks);
    end
    rxd <= 1'b1;
    tick(bit_clks);
  endtask

  ////////////////////////////////////////////////////////////
  // Stops at mid stop bit so a back-to-back start is not lost
  always begin : listen
    logic [10:0] s;
    @(negedge txd);
    tick(bit_clks / 2);
    s[0] = txd;
    for (int i = 1; i <= 9 + pe; i++) begin
      tick(bit_clks);
      s[i] = txd;
    end
    got_byte = s[8:1];
    got_bad = s[0] | ~s[9 + pe] | (pe & (s[9] ^ (^s[8:1]) ^ ~even));
    got <= 1'b1;
    @(posedge core_clk);
    got <= 1'b0;
  end
endmodule // asu_remote

// File: testbench/test_async_serial_uart.sv
`timescale 1ns/1ps
module test_async_serial_uart;
  import asu_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic  [7:0] addr     = 8'h00;
  logic  [7:0] wdata    = 8'h00;
  logic        wr_stb   = 1'b0;
  logic        rd_stb   = 1'b0;
  logic        pe_m     = 1'b0;
  logic        even_m   = 1'b0;
  logic        rd_q     = 1'b0;
  logic [15:0] bclk_m   = 16'h0020;
  logic  [7:0] rdata;
  logic  [7:0] got_byte;
  logic        rxd, txd, tx_irq, rx_irq, got, got_bad;
  logic  [7:0] exp_q[$];
  logic  [7:0] exp_tx[$];
  logic  [7:0] cfg_c[3] = '{8'hDE, 8'hEE, 8'hE0};
  logic  [7:0] cfg_t[3] = '{8'h02, 8'h03, 8'h01};
  logic  [7:0] held = ASU_BUF_RST;
  int          n_errors = 0, checks_done = 0, n_tx = 0, n_rx = 0;
  int          exp_rx = 0, cyc = 0, t_last = 0, gap = 0;

  always #10 core_clk = ~core_clk;

  asu_core u_asu_core (.core_clk(core_clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .rxd(rxd), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq));

  asu_remote u_asu_remote (.core_clk(core_clk), .txd(txd), .bit_clks(bclk_m),
    .pe(pe_m), .even(even_m), .rxd(rxd), .got(got), .got_byte(got_byte),
    .got_bad(got_bad));

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic test_done;
    $display("errors %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    rd_stb <= 1'b0;
  endtask

  task automatic rx(input logic [7:0] d, input logic bp, bs, ld);
    u_asu_remote.send(d, bp, bs);
    exp_rx += ld;
  endtask

  // Watcher: read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    cyc  <= cyc + 1;
    rd_q <= rd_stb;
    if (rd_q) check(rdata, exp_q.pop_front());
    if (got) check({got_bad, got_byte}, {1'b0, exp_tx.pop_front()});
    if (tx_irq === 1'b1) begin
      gap    <= cyc - t_last;
      t_last <= cyc;
      n_tx   <= n_tx + 1;
    end
    if (rx_irq === 1'b1) n_rx <= n_rx + 1;
  end

  ////////////////////////////////////////////////////////////
  initial begin : main
    logic [7:0] c;
    logic [7:0] d[4];
    int n, bclk, fb;
    void'($urandom(51));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(ASU_STATUS_ADDR, 8'h0C);
    rd(ASU_TMATCH_ADDR, ASU_TMATCH_RST);
    rd(8'h30, 8'h00);
    for (int k = 0; k < 3; k++) begin
      c = cfg_c[k];
      n = (c[2:0] == ASU_BRG_TIMER) ? int'(cfg_t[k])
                                    : int'(ASU_DIV_BASE) << c[2:0];
      bclk = 16 * n;
      fb = 10 + c[ASU_PE] + c[ASU_STOP];
      foreach (d[i]) d[i] = 8'($urandom);
      wr(ASU_CTRL_ADDR, 8'h00);
      check(txd, 1'b1);
      pe_m   <= c[ASU_PE];
      even_m <= c[ASU_EVEN];
      bclk_m <= bclk[15:0];
      wr(ASU_TMATCH_ADDR, cfg_t[k]);
      wr(ASU_CTRL_ADDR, c);
      rd(ASU_BUF_ADDR, held);
      wr(ASU_BUF_ADDR, 8'h55);
      tick(bclk);
      check(txd, 1'b1);
      rd(ASU_STATUS_ADDR, 8'h0C);
      exp_tx.push_back(d[0]);
      exp_tx.push_back(d[1]);
      wr(ASU_BUF_ADDR, d[0]);
      rd(ASU_STATUS_ADDR, 8'h04);
      wr(ASU_BUF_ADDR, d[1]);
      rd(ASU_STATUS_ADDR, 8'h00);
      for (int i = 0; i < 40 * bclk && exp_tx.size() > 0; i++) tick(1);
      if (exp_tx.size() > 0) begin
        n_errors++;
        test_done;
      end
      // Start bit launches off the tick grid, so it runs short by under a tick
      check(gap+n >= fb*bclk+2 && gap <= fb*bclk+1, 1'b1);
      tick(2 * bclk);
      rd(ASU_STATUS_ADDR, 8'h0C);
      rx(d[0], 1'b0, 1'b0, 1'b1);
      rd(ASU_STATUS_ADDR, 8'h1C);
      rd(ASU_BUF_ADDR, d[0]);
      rd(ASU_STATUS_ADDR, 8'h0C);
      rx(d[1], 1'b0, 1'b0, 1'b1);
      rx(d[2], 1'b0, 1'b0, 1'b0);
      rx(d[3], 1'b0, 1'b0, 1'b0);
      rd(ASU_STATUS_ADDR, 8'h3C);
      rd(ASU_BUF_ADDR, d[1]);
      rd(ASU_STATUS_ADDR, 8'h0C);
      rx(d[2], 1'b0, 1'b0, 1'b1);
      rd(ASU_STATUS_ADDR, 8'h1C);
      rx(d[3], 1'b0, 1'b0, 1'b0);
      rd(ASU_BUF_ADDR, d[2]);
      rd(ASU_STATUS_ADDR, 8'h2C);
      rd(ASU_BUF_ADDR, d[2]);
      rd(ASU_STATUS_ADDR, 8'h0C);
      for (int j = c[ASU_PE] ? 0 : 1; j < 2; j++) begin
        rx(d[j], j == 0, j == 1, 1'b1);
        rd(ASU_STATUS_ADDR, j ? 8'h5C : 8'h9C);
        rd(ASU_BUF_ADDR, d[j]);
        rd(ASU_STATUS_ADDR, 8'h0C);
      end
      held = d[1];
      tick(bclk);
    end
    check(n_tx, 6);
    check(n_rx, exp_rx);
    test_done;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
endmodule // test_async_serial_uart
